// ---- verilog/uifl_consts.svh ----
`ifndef UIFL_CONSTS_SVH
`define UIFL_CONSTS_SVH

// Register addresses on the 3-bit port
`define UIFL_ADDR_DATA    3'h0
`define UIFL_ADDR_IER     3'h1
`define UIFL_ADDR_ISR_FCR 3'h2
`define UIFL_ADDR_LCR     3'h3
`define UIFL_ADDR_LSR     3'h5
`define UIFL_ADDR_MSR     3'h6
`define UIFL_ADDR_EFR     3'h7

// Field positions
`define UIFL_EFR_ENH      4
`define UIFL_EFR_ARTS     6
`define UIFL_EFR_ACTS     7
`define UIFL_FCR_EN       0
`define UIFL_FCR_RXRST    1
`define UIFL_FCR_TXRST    2
`define UIFL_FCR_DMA      3

// Reset values
`define UIFL_IER_RST      8'h00
`define UIFL_EFR_RST      8'h00
`define UIFL_LCR_RST      8'h00

// Source codes, highest priority first
`define UIFL_ID_LSR       6'h06
`define UIFL_ID_TMO       6'h0c
`define UIFL_ID_RXD       6'h04
`define UIFL_ID_TXR       6'h02
`define UIFL_ID_MSR       6'h00
`define UIFL_ID_XOF       6'h10
`define UIFL_ID_PIN       6'h20
`define UIFL_ID_NONE      6'h01

// Receive timeout figures, in characters and bit times
`define UIFL_TMO_CHARS    7'd4
`define UIFL_TMO_BITS     7'd12

`endif

// ---- verilog/uifl_pkg.sv ----
`default_nettype none
package uifl_pkg;

  // ---------------------------------------------------------------
  // Line format handed to the serializer and deserializer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] word_len_sel;   // 0..3 means 5..8 data bits
    logic       stop_long;      // 1.5 stop for 5 bits, else 2
    logic       parity_en;      // Parity bit present
    logic       parity_even;    // Even when set, odd when clear
  } uifl_line_cfg_t;

  // ---------------------------------------------------------------
  // Whole register state of the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] interrupt_enable_reg;            // Interrupt enables
    logic [7:0] enhanced_function_reg;            // Enhanced function bits
    logic [7:0] line_control_reg;            // Line control
    logic       fifo_en;        // FIFOs enabled
    logic       dma_mode;       // Pin mode select
    logic [1:0] trig_sel;       // Receive trigger code
    logic       rx_rst;         // Receive FIFO reset pulse
    logic       tx_rst;         // Transmit FIFO reset pulse
    logic       lsr_flag;       // Line status source
    logic       tmo_flag;       // Receive timeout source
    logic       tx_flag;        // Transmit ready source
    logic       msr_flag;       // Modem status source
    logic       xoff_flag;      // Received Xoff
    logic       spc_flag;       // Special character match
    logic       pin_flag;       // RTS/CTS rise
    logic [5:0] cur_id;         // Source code shown in status
    logic [6:0] tmr;            // Timeout counter in bit times
    logic       cts_s1;         // Synchroniser stage 1
    logic       cts_s2;         // Synchroniser stage 2
    logic       cts_prev;       // Previous synced CTS level
    logic       rts_prev;       // Previous RTS level
    logic       lsr_prev;       // Previous line error summary
    logic       txe_prev;       // Previous transmit empty
    logic [7:0] rdata;          // Read data register
  } uifl_state_t;

endpackage : uifl_pkg
`default_nettype wire

// ---- verilog/uifl_core.sv ----
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "uifl_consts.svh"

module uifl_core #(
  parameter int unsigned LVL_W = 5          // Width of FIFO level inputs
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // Register port
  input  wire logic [2:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  // Status from the rest of the channel
  input  wire logic [7:0]              rhr_data,
  input  wire logic [7:0]              lsr_data,
  input  wire logic [7:0]              msr_data,
  input  wire logic [LVL_W-1:0]        rx_level,
  input  wire logic                    tx_empty,
  input  wire logic                    tx_full,
  input  wire logic                    bit_tick,
  input  wire logic                    rx_char_done,
  input  wire logic                    xoff_det,
  input  wire logic                    xon_det,
  input  wire logic                    special_det,
  input  wire logic                    rts_n,
  input  wire logic                    cts_n_pin,
  // Controls to the rest of the channel
  output logic                         rhr_rd,
  output logic                         thr_wr,
  output logic                         fifo_en,
  output logic                         dma_mode,
  output logic                         rx_fifo_rst,
  output logic                         tx_fifo_rst,
  output logic [LVL_W-1:0]             rx_trig_lvl,
  output uifl_pkg::uifl_line_cfg_t     line_cfg,
  output logic                         transmit_ready_pin_n,
  output logic                         receive_ready_pin_n,
  output logic                         irq
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Trigger code to character count; FIFO off means one character
  function automatic logic [LVL_W-1:0] trig_of(input logic en, input logic [1:0] sel);
    logic [LVL_W-1:0] v;
    v = LVL_W'(1);
    if (en) begin
      case (sel)
        2'b00:   v = LVL_W'(1);
        2'b01:   v = LVL_W'(4);
        2'b10:   v = LVL_W'(8);
        2'b11:   v = LVL_W'(14);
        default: v = LVL_W'(1);
      endcase
    end
    return v;
  endfunction : trig_of

  // Timeout limit in bit times; a 1.5 stop is rounded up to 2
  function automatic logic [6:0] tmo_limit(input logic [7:0] line_control_reg);
    logic [6:0] chr;
    chr = 7'd6 + {5'h00, line_control_reg[1:0]} + {6'h00, line_control_reg[3]} + (line_control_reg[2] ? 7'd2 : 7'd1);
    return 7'((`UIFL_TMO_CHARS * chr) + `UIFL_TMO_BITS);
  endfunction : tmo_limit

  // ---------------------------------------------------------------
  // State and strobes
  // ---------------------------------------------------------------
  uifl_pkg::uifl_state_t s_ff;        // Registered state
  uifl_pkg::uifl_state_t nxt_s;       // Next state
  logic                  isr_rd;      // Status register read
  logic                  lsr_rd;      // Line status read
  logic                  msr_rd;      // Modem status read
  logic                  fcr_wr;      // FIFO control write
  logic                  enh;         // Enhanced bits effective
  logic                  rx_at_trig;  // Level at or above trigger
  logic                  lsr_any;     // Any line error bit
  logic [7:0]            p;           // Pending, priority order
  logic [5:0]            top_id;      // Highest pending code
  logic                  cur_live;    // Shown source still pending
  logic                  cts_rise;    // CTS went high
  logic                  rts_rise;    // RTS went high
  logic                  tmo_set;     // Timer expiry this cycle

  assign isr_rd = reg_rd && (reg_addr == `UIFL_ADDR_ISR_FCR);
  assign lsr_rd = reg_rd && (reg_addr == `UIFL_ADDR_LSR);
  assign msr_rd = reg_rd && (reg_addr == `UIFL_ADDR_MSR);
  assign rhr_rd = reg_rd && (reg_addr == `UIFL_ADDR_DATA);
  assign thr_wr = reg_wr && (reg_addr == `UIFL_ADDR_DATA);
  assign fcr_wr = reg_wr && (reg_addr == `UIFL_ADDR_ISR_FCR);
  assign enh    = s_ff.enhanced_function_reg[`UIFL_EFR_ENH];
  assign lsr_any = |lsr_data[4:1];
  assign rx_at_trig = (rx_level >= trig_of(s_ff.fifo_en, s_ff.trig_sel));
  assign cts_rise = s_ff.cts_s2 && !s_ff.cts_prev;
  assign rts_rise = rts_n && !s_ff.rts_prev;

  // ---------------------------------------------------------------
  // Pending sources, gated by their enables
  // ---------------------------------------------------------------
  always_comb begin
    p[0] = s_ff.lsr_flag && s_ff.interrupt_enable_reg[2];
    p[1] = s_ff.tmo_flag && s_ff.interrupt_enable_reg[0];
    p[2] = rx_at_trig && s_ff.interrupt_enable_reg[0];
    p[3] = s_ff.tx_flag && s_ff.interrupt_enable_reg[1];
    p[4] = s_ff.msr_flag && s_ff.interrupt_enable_reg[3];
    // Upper enables only bite with enhanced mode on
    p[5] = enh && s_ff.interrupt_enable_reg[5] && (s_ff.xoff_flag || s_ff.spc_flag);
    p[6] = enh && s_ff.pin_flag;
    p[7] = 1'b0;
  end

  // Highest pending code in fixed order
  always_comb begin
    if (p[0]) begin
      top_id = `UIFL_ID_LSR;
    end else if (p[1]) begin
      top_id = `UIFL_ID_TMO;
    end else if (p[2]) begin
      top_id = `UIFL_ID_RXD;
    end else if (p[3]) begin
      top_id = `UIFL_ID_TXR;
    end else if (p[4]) begin
      top_id = `UIFL_ID_MSR;
    end else if (p[5]) begin
      top_id = `UIFL_ID_XOF;
    end else if (p[6]) begin
      top_id = `UIFL_ID_PIN;
    end else begin
      top_id = `UIFL_ID_NONE;
    end
  end

  // Is the code now shown still backed by a pending source
  always_comb begin
    case (s_ff.cur_id)
      `UIFL_ID_LSR: cur_live = p[0];
      `UIFL_ID_TMO: cur_live = p[1];
      `UIFL_ID_RXD: cur_live = p[2];
      `UIFL_ID_TXR: cur_live = p[3];
      `UIFL_ID_MSR: cur_live = p[4];
      `UIFL_ID_XOF: cur_live = p[5];
      `UIFL_ID_PIN: cur_live = p[6];
      default:      cur_live = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    tmo_set = 1'b0;
    nxt_s.rx_rst = 1'b0;
    nxt_s.tx_rst = 1'b0;

    // Synchroniser and edge history
    nxt_s.cts_s1   = cts_n_pin;
    nxt_s.cts_s2   = s_ff.cts_s1;
    nxt_s.cts_prev = s_ff.cts_s2;
    nxt_s.rts_prev = rts_n;
    nxt_s.lsr_prev = lsr_any;
    nxt_s.txe_prev = tx_empty;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `UIFL_ADDR_IER: nxt_s.interrupt_enable_reg = reg_wdata;
        `UIFL_ADDR_LCR: nxt_s.line_control_reg = reg_wdata;
        `UIFL_ADDR_EFR: nxt_s.enhanced_function_reg = reg_wdata;
        `UIFL_ADDR_ISR_FCR: begin
          nxt_s.fifo_en = reg_wdata[`UIFL_FCR_EN];
          // Other bits only land with the enable bit in the same write
          if (reg_wdata[`UIFL_FCR_EN]) begin
            nxt_s.rx_rst   = reg_wdata[`UIFL_FCR_RXRST];
            nxt_s.tx_rst   = reg_wdata[`UIFL_FCR_TXRST];
            nxt_s.dma_mode = reg_wdata[`UIFL_FCR_DMA];
            nxt_s.trig_sel = reg_wdata[7:6];
          end
        end
        default: ;
      endcase
    end

    // Timeout counter: idles while empty, restarts on traffic
    if (!s_ff.fifo_en || (rx_level == '0) || rhr_rd || rx_char_done) begin
      nxt_s.tmr = 7'd0;
    end else if (bit_tick && (s_ff.tmr != tmo_limit(s_ff.line_control_reg))) begin
      nxt_s.tmr = s_ff.tmr + 7'd1;
      tmo_set   = (nxt_s.tmr == tmo_limit(s_ff.line_control_reg));
    end

    // Sticky sources; in each the set is tested last so it wins
    if (lsr_rd) begin
      nxt_s.lsr_flag = 1'b0;
    end
    if (lsr_any && !s_ff.lsr_prev) begin
      nxt_s.lsr_flag = 1'b1;
    end

    if (rhr_rd) begin
      nxt_s.tmo_flag = 1'b0;
    end
    if (tmo_set) begin
      nxt_s.tmo_flag = 1'b1;
    end

    // Status read clears transmit only when it is the code shown
    if (thr_wr || (isr_rd && (s_ff.cur_id == `UIFL_ID_TXR))) begin
      nxt_s.tx_flag = 1'b0;
    end
    if (tx_empty && !s_ff.txe_prev) begin
      nxt_s.tx_flag = 1'b1;
    end

    if (msr_rd) begin
      nxt_s.msr_flag = 1'b0;
      nxt_s.pin_flag = 1'b0;
    end
    if (|msr_data[3:0]) begin
      nxt_s.msr_flag = 1'b1;
    end
    // Rises count only with auto flow and the matching enable
    if (enh && ((cts_rise && s_ff.enhanced_function_reg[`UIFL_EFR_ACTS] && s_ff.interrupt_enable_reg[7]) ||
                (rts_rise && s_ff.enhanced_function_reg[`UIFL_EFR_ARTS] && s_ff.interrupt_enable_reg[6]))) begin
      nxt_s.pin_flag = 1'b1;
    end

    if (isr_rd || xon_det) begin
      nxt_s.xoff_flag = 1'b0;
    end
    if (xoff_det) begin
      nxt_s.xoff_flag = 1'b1;
    end
    // The match character itself must not clear its own flag
    if (isr_rd || (rx_char_done && !special_det)) begin
      nxt_s.spc_flag = 1'b0;
    end
    if (special_det) begin
      nxt_s.spc_flag = 1'b1;
    end

    // Shown code is held until its source is serviced
    if (!cur_live) begin
      nxt_s.cur_id = top_id;
    end

    // Read data, valid in the cycle after the strobe
    nxt_s.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `UIFL_ADDR_DATA:    nxt_s.rdata = rhr_data;
        `UIFL_ADDR_IER:     nxt_s.rdata = s_ff.interrupt_enable_reg;
        `UIFL_ADDR_ISR_FCR: nxt_s.rdata = {{2{s_ff.fifo_en}}, s_ff.cur_id};
        `UIFL_ADDR_LCR:     nxt_s.rdata = s_ff.line_control_reg;
        `UIFL_ADDR_LSR:     nxt_s.rdata = lsr_data;
        `UIFL_ADDR_MSR:     nxt_s.rdata = msr_data;
        `UIFL_ADDR_EFR:     nxt_s.rdata = s_ff.enhanced_function_reg;
        default:            nxt_s.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff        <= '0;
      s_ff.interrupt_enable_reg    <= `UIFL_IER_RST;
      s_ff.enhanced_function_reg    <= `UIFL_EFR_RST;
      s_ff.line_control_reg    <= `UIFL_LCR_RST;
      s_ff.cur_id <= `UIFL_ID_NONE;
      // Edge history starts at the idle pin levels so no false rise follows reset
      s_ff.cts_s1   <= 1'b1;
      s_ff.cts_s2   <= 1'b1;
      s_ff.cts_prev <= 1'b1;
      s_ff.rts_prev <= 1'b1;
      s_ff.txe_prev <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata   = s_ff.rdata;
  assign fifo_en     = s_ff.fifo_en;
  assign dma_mode    = s_ff.dma_mode;
  assign rx_fifo_rst = s_ff.rx_rst;
  assign tx_fifo_rst = s_ff.tx_rst;
  assign rx_trig_lvl = trig_of(s_ff.fifo_en, s_ff.trig_sel);
  assign line_cfg.word_len_sel = s_ff.line_control_reg[1:0];
  assign line_cfg.stop_long    = s_ff.line_control_reg[2];
  assign line_cfg.parity_en    = s_ff.line_control_reg[3];
  assign line_cfg.parity_even  = s_ff.line_control_reg[4];
  assign irq = (s_ff.cur_id != `UIFL_ID_NONE);

  // Normal mode signals single bytes; DMA mode signals blocks
  assign transmit_ready_pin_n = s_ff.dma_mode ? tx_full : !tx_empty;
  assign receive_ready_pin_n  = s_ff.dma_mode ? !(rx_at_trig || s_ff.tmo_flag)
                                              : (rx_level == '0);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence seq_fcr_on(logic [7:0] v);
    fcr_wr && (reg_wdata == v);
  endsequence

  property p_fcr_gate;
    fcr_wr && !reg_wdata[0] |=> !fifo_en && $stable(dma_mode) && $stable(s_ff.trig_sel);
  endproperty
  a_fcr_gate: assert property (p_fcr_gate) else $error("fifo control gate broken");

  property p_rst_pulse;
    seq_fcr_on(8'h07) |=> rx_fifo_rst && tx_fifo_rst ##1 !rx_fifo_rst && !tx_fifo_rst;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("fifo reset not one pulse");

  property p_trig14;
    seq_fcr_on(8'hc1) |=> (rx_trig_lvl == LVL_W'(14)) && fifo_en;
  endproperty
  a_trig14: assert property (p_trig14) else $error("trigger not fourteen");

  property p_isr_read;
    isr_rd |=> (reg_rdata[7:6] == {2{$past(fifo_en)}}) &&
               (reg_rdata[0] == !$past(irq));
  endproperty
  a_isr_read: assert property (p_isr_read) else $error("status read bits wrong");

  property p_hold;
    irq && cur_live |=> $stable(s_ff.cur_id);
  endproperty
  a_hold: assert property (p_hold) else $error("shown source changed early");

  property p_thr_clr;
    thr_wr && !(tx_empty && !s_ff.txe_prev) |=> !s_ff.tx_flag;
  endproperty
  a_thr_clr: assert property (p_thr_clr) else $error("transmit flag not cleared");

  property p_msr_clr;
    msr_rd && !(|msr_data[3:0]) |=> !s_ff.msr_flag;
  endproperty
  a_msr_clr: assert property (p_msr_clr) else $error("modem flag not cleared");

  property p_tmo_clr;
    rhr_rd |=> !s_ff.tmo_flag ##1 !s_ff.tmo_flag;
  endproperty
  a_tmo_clr: assert property (p_tmo_clr) else $error("timeout survived data read");

  property p_no_enh;
    !enh |-> (s_ff.cur_id != `UIFL_ID_XOF) || $past(enh);
  endproperty
  a_no_enh: assert property (p_no_enh) else $error("upper source without enhanced mode");

endmodule : uifl_core
`default_nettype wire

// ---- verification/uifl_chan_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// FIFO level model of the rest of the channel
// ----------------------------------------
module uifl_chan_model #(
  parameter int unsigned DEPTH = 16   // Entries per FIFO
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       rhr_rd,
  input  wire logic       thr_wr,
  input  wire logic       rx_fifo_rst,
  input  wire logic       tx_fifo_rst,
  input  wire logic       rx_push,    // Char arrives from the line
  input  wire logic       tx_pop,     // Char leaves for the line
  output logic [4:0]      rx_level,
  output logic            tx_empty,
  output logic            tx_full
);
  logic [4:0] tx_cnt_ff;  // Transmit entries held

  // Levels move by one; a reset pulse wins so stale data never returns
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_level  <= 5'h00;
      tx_cnt_ff <= 5'h00;
    end else begin
      if (rx_fifo_rst)
        rx_level <= 5'h00;
      else if (rx_push && !rhr_rd && rx_level < 5'(DEPTH))
        rx_level <= rx_level + 5'h01;
      else if (rhr_rd && !rx_push && rx_level != 5'h00)
        rx_level <= rx_level - 5'h01;
      if (tx_fifo_rst)
        tx_cnt_ff <= 5'h00;
      else if (thr_wr && !tx_full)
        tx_cnt_ff <= tx_cnt_ff + 5'h01;
      else if (tx_pop && !tx_empty)
        tx_cnt_ff <= tx_cnt_ff - 5'h01;
    end
  end

  assign tx_empty = (tx_cnt_ff == 5'h00);
  assign tx_full  = (tx_cnt_ff == 5'(DEPTH));
endmodule : uifl_chan_model
`default_nettype wire

// ---- verification/uifl_core_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module uifl_core_test;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} uifl_row_t;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, bit_tick = 0, rts_n = 1;
  logic xoff_det = 0, xon_det = 0, rx_push = 0, tx_pop = 0, txp_n, rxp_n;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, lsr_data = 8'h00, msr_data = 8'h00, reg_rdata, v;
  logic rhr_rd, thr_wr, fifo_en, dma_mode, rx_fifo_rst, tx_fifo_rst, irq, tx_empty, tx_full;
  logic [4:0] rx_level, rx_trig_lvl;
  uifl_pkg::uifl_line_cfg_t line_cfg;
  int errors = 0, compares = 0, n;
  // Written value beside trigger level (FIFO control) or readback (line control)
  uifl_row_t rows [10] = '{'{3'h2, 8'h01, 8'h01}, '{3'h2, 8'h49, 8'h04},
    '{3'h2, 8'h41, 8'h04}, '{3'h2, 8'h81, 8'h08}, '{3'h2, 8'hc1, 8'h0e},
    '{3'h2, 8'hc8, 8'h01}, '{3'h3, 8'h03, 8'h03}, '{3'h3, 8'h0e, 8'h0e},
    '{3'h3, 8'h1d, 8'h1d}, '{3'h3, 8'h00, 8'h00}};

  uifl_core uifl_core_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rhr_data(8'h5a), .lsr_data(lsr_data), .msr_data(msr_data), .rx_level(rx_level),
    .tx_empty(tx_empty), .tx_full(tx_full), .bit_tick(bit_tick), .rx_char_done(rx_push),
    .xoff_det(xoff_det), .xon_det(xon_det), .special_det(1'b0), .rts_n(rts_n),
    .cts_n_pin(1'b1), .rhr_rd(rhr_rd), .thr_wr(thr_wr), .fifo_en(fifo_en),
    .dma_mode(dma_mode), .rx_fifo_rst(rx_fifo_rst), .tx_fifo_rst(tx_fifo_rst),
    .rx_trig_lvl(rx_trig_lvl), .line_cfg(line_cfg), .transmit_ready_pin_n(txp_n),
    .receive_ready_pin_n(rxp_n), .irq(irq));

  uifl_chan_model uifl_chan_model_inst (.mclk(mclk), .rst_n(rst_n), .rhr_rd(rhr_rd),
    .thr_wr(thr_wr), .rx_fifo_rst(rx_fifo_rst), .tx_fifo_rst(tx_fifo_rst),
    .rx_push(rx_push), .tx_pop(tx_pop), .rx_level(rx_level), .tx_empty(tx_empty),
    .tx_full(tx_full));

  // 50 ns period
  initial begin
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------
  // Bus tasks; a gap cycle follows each strobe
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic interrupt_status_reg(input logic [7:0] e);
    logic [7:0] d;
    rd(3'h2, d);
    `CHK(d, e)
  endtask : interrupt_status_reg

  // Bounded wait so a dead source cannot hang the run
  task automatic wait_irq(output int k);
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #1 k++;
    end
    `CHK(irq, 1'b1)
  endtask : wait_irq

  task automatic close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Whole sequence needs about 200 cycles; the 8000-cycle limit allows forty times that
  initial begin
    #(50 * 8000);
    errors++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    `CHK(irq, 1'b0)
    rst_n <= 1'b1;
    interrupt_status_reg(8'h01);
    rd(3'h4, v);
    `CHK(v, 8'h00)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      @(posedge mclk);
      #1;
      if (rows[i].a == 3'h2) begin
        `CHK({3'h0, rx_trig_lvl}, rows[i].e)
        `CHK(dma_mode, rows[i].d[0] & rows[i].d[3])
        `CHK(fifo_en, rows[i].d[0])
      end else begin
        `CHK(line_cfg, {rows[i].d[1:0], rows[i].d[2], rows[i].d[3], rows[i].d[4]})
        rd(3'h3, v);
        `CHK(v, rows[i].e)
      end
    end
    wr(3'h2, 8'h07);
    #1 `CHK(rx_fifo_rst & tx_fifo_rst, 1'b1)
    @(posedge mclk);
    #1 `CHK(rx_fifo_rst | tx_fifo_rst, 1'b0)
    interrupt_status_reg(8'hc1);
    // Receive and transmit sources set together; receive outranks
    wr(3'h0, 8'h55);
    wr(3'h1, 8'h03);
    @(posedge mclk);
    rx_push <= 1'b1; tx_pop <= 1'b1;
    @(posedge mclk);
    rx_push <= 1'b0; tx_pop <= 1'b0;
    repeat (3) @(posedge mclk);
    interrupt_status_reg(8'hc4);
    rd(3'h0, v);
    repeat (2) @(posedge mclk);
    // Normal pin mode: receive empty, transmit empty
    `CHK({txp_n, rxp_n}, 2'b01)
    interrupt_status_reg(8'hc2);
    interrupt_status_reg(8'hc1);
    `CHK(irq, 1'b0)
    // Timeout at 5 bits, one stop: 4 chars of 7 bit times plus 12
    wr(3'h2, 8'h47);
    wr(3'h1, 8'h01);
    @(posedge mclk);
    rx_push <= 1'b1; bit_tick <= 1'b1;
    @(posedge mclk);
    rx_push <= 1'b0;
    wait_irq(n);
    `CHK(n inside {[38:48]}, 1'b1)
    interrupt_status_reg(8'hcc);
    rd(3'h0, v);
    bit_tick <= 1'b0;
    interrupt_status_reg(8'hc1);
    // Line error stays flagged after the read that clears the source
    wr(3'h1, 8'h04);
    lsr_data <= 8'h02;
    wait_irq(n);
    interrupt_status_reg(8'hc6);
    rd(3'h5, v);
    `CHK(v, 8'h02)
    interrupt_status_reg(8'hc1);
    lsr_data <= 8'h00;
    wr(3'h1, 8'h08);
    msr_data <= 8'h01;
    wait_irq(n);
    interrupt_status_reg(8'hc0);
    msr_data <= 8'h10;
    rd(3'h6, v);
    interrupt_status_reg(8'hc1);
    // Xoff ignored until the enhanced bit is set
    wr(3'h1, 8'h20);
    @(posedge mclk);
    xoff_det <= 1'b1;
    @(posedge mclk);
    xoff_det <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(3'h7, 8'h10);
    @(posedge mclk);
    xoff_det <= 1'b1;
    @(posedge mclk);
    xoff_det <= 1'b0;
    wait_irq(n);
    interrupt_status_reg(8'hd0);
    // Set the flag again so that only the Xon can clear it
    @(posedge mclk);
    xoff_det <= 1'b1;
    @(posedge mclk);
    xoff_det <= 1'b0;
    wait_irq(n);
    @(posedge mclk);
    xon_det <= 1'b1;
    @(posedge mclk);
    xon_det <= 1'b0;
    repeat (3) @(posedge mclk);
    interrupt_status_reg(8'hc1);
    // Request-to-send rise under automatic flow control
    wr(3'h1, 8'h40);
    wr(3'h7, 8'h50);
    rts_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rts_n <= 1'b1;
    wait_irq(n);
    interrupt_status_reg(8'he0);
    rd(3'h6, v);
    interrupt_status_reg(8'hc1);
    close_out();
  end
endmodule : uifl_core_test
`default_nettype wire
